//--- verilog/sock1_pkg.sv
package sock1_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] CTRL_ADDR   = 4'h0;
	localparam logic [3:0] SLEEP_ADDR  = 4'h1;
	localparam logic [3:0] STATUS_ADDR = 4'h2;
	localparam logic [3:0] IRQ_ST_ADDR = 4'h3;
	localparam logic [3:0] IRQ_MK_ADDR = 4'h4;
	localparam logic [3:0] MODE_ADDR   = 4'h5;
	// control register fields
	localparam int CTRL_FLOAT_BIT = 3;
	localparam int CTRL_WAITEN_BIT = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// sleep state register field
	localparam int SLEEP_S1_BIT = 1;
	localparam logic [1:0] SLEEP_RESET = 2'h0;
	// mode register: bit 0 sleep, bit 1 io read select polarity
	localparam int MODE_SLEEP_BIT = 0;
	localparam int MODE_IORD_POL_BIT = 1;
	localparam logic [1:0] MODE_RESET = 2'h0;
	// status register fields
	localparam int ST_READY_BIT  = 1;
	localparam int ST_CDV_BIT    = 3;
	localparam int ST_VS1_BIT    = 6;
	localparam int ST_VS2_BIT    = 7;
	localparam int ST_IO16_BIT   = 9;
	localparam int ST_BVD1_BIT   = 12;
	localparam int ST_BVD2_BIT   = 13;
	// interrupt status/mask fields
	localparam int IRQ_READY_BIT = 0;
	localparam int IRQ_BVD1_BIT  = 1;
	localparam int IRQ_CDV_BIT   = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	// synchroniser depth for card pins
	localparam int SYNC_STAGES = 3;
endpackage

//--- verilog/sock1_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output moves once stages two and three agree
module sock1_sync #(
	parameter int        WIDTH = 1,
	parameter logic [0:0] INIT = 1'b1
) (
	input  wire logic             CLK,
	input  wire logic             SYS_RST,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;

	// chain; first stage feeds only the second
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s1_ff <= {WIDTH{INIT}};
			s2_ff <= {WIDTH{INIT}};
			s3_ff <= {WIDTH{INIT}};
		end else begin
			s1_ff <= D;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// per-bit agreement filter rejects a single-cycle disagreement
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			Q <= {WIDTH{INIT}};
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					Q[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule

//--- verilog/sock1_edge.sv
`timescale 1ns/100ps
// sticky event flag: sets on a change of the watched level, read clears
module sock1_edge (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic LEVEL,
	input  wire logic CLR,
	output logic      FLAG
);
	logic prev_ff;
	logic hit;

	assign hit = LEVEL ^ prev_ff;

	// every watched level idles high out of reset; a low start would
	// fake an event on the first edge after release
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prev_ff <= 1'b1;
		end else begin
			prev_ff <= LEVEL;
		end
	end

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			FLAG <= 1'b0;
		end else if (hit) begin
			FLAG <= 1'b1;
		end else if (CLR) begin
			FLAG <= 1'b0;
		end
	end
endmodule

//--- verilog/sock1_gate.sv
`timescale 1ns/100ps
// Functional notes
// R1: card enables pass only when detected, selected
// R2: sleep: sleep bit zero floats, one drives high
// R3: float bit clear floats every strobe output
// R4: output enable gated by detect and select
// R5: write enable gated by detect and select
// R6: io read gated, select polarity is configurable
// R7: io write gated by detect and select
// R8: host wait follows card wait input; the code passes it only while the wait enable bit is set, else holds it high
// R9: io16 drives host io16 and status
// R10: ready readable and an interrupt source
// R11: bvd1 status change readable and interrupt
// R12: bvd2 speaker readable in status
// R13: both voltage sense inputs readable
// R14: detect valid zero when both detects low
// R15: software sets float bit to enable outputs
// R16: socket one sleep state from bit one
// R17: card inputs synchronised before status use
module sock1_gate
	import sock1_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	output logic             IRQ,
	input  wire logic        SOCKET_SELECT,
	input  wire logic [1:0]  HOST_CARD_ENABLE_N,
	input  wire logic        HOST_OUTPUT_ENABLE_N,
	input  wire logic        HOST_WRITE_ENABLE_N,
	input  wire logic        HOST_IO_READ_N,
	input  wire logic        HOST_IO_WRITE_N,
	output logic             HOST_WAIT_N,
	output logic             HOST_IO16_N,
	output logic [1:0]       SOCK1_CARD_ENABLE_N,
	output logic [1:0]       SOCK1_CARD_ENABLE_OE,
	output logic             SOCK1_OUTPUT_ENABLE_N,
	output logic             SOCK1_OUTPUT_ENABLE_OE,
	output logic             SOCK1_WRITE_ENABLE_N,
	output logic             SOCK1_WRITE_ENABLE_OE,
	output logic             SOCK1_IO_READ_N,
	output logic             SOCK1_IO_READ_OE,
	output logic             SOCK1_IO_WRITE_N,
	output logic             SOCK1_IO_WRITE_OE,
	input  wire logic        SOCK1_WAIT_IN_N,
	input  wire logic        SOCK1_IO16_IN_N,
	input  wire logic        SOCK1_READY_IRQ,
	input  wire logic        SOCK1_BATT1_STATUS_CHANGE,
	input  wire logic        SOCK1_BATT2_SPEAKER,
	input  wire logic [1:0]  SOCK1_VOLTAGE_SENSE_N,
	input  wire logic [1:0]  SOCK1_CARD_DETECT_N
);
	import sock1_pkg::*;

	logic [7:0]     card_control_reg_ff;
	logic [1:0]     card_sleep_state_reg_ff;
	logic [1:0]     mode_ff;
	logic [2:0]     irq_mask_ff;
	logic [2:0]     irq_flag;
	logic           wait_s;
	logic           io16_s;
	logic           ready_s;
	logic           bvd1_s;
	logic           bvd2_s;
	logic [1:0]     vs_s;
	logic [1:0]     cd_s;
	logic           sock1_detect_valid_n;
	logic           float_en;
	logic           sleep_mode;
	logic           sleep_drive;
	logic           sel_ok;
	logic           iord_sel_ok;
	logic           irq_clr;
	logic [15:0]    status_word;
	logic [15:0]    nxt_rdata;
	logic [1:0]     ce_n;
	logic           oe_n;
	logic           we_n;
	logic           iord_n;
	logic           iowr_n;
	logic           strobe_oe;

	// card pins are asynchronous; idle levels high to avoid reset glitches
	sock1_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_wait (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_WAIT_IN_N),
		.Q       (wait_s)
	); // R17

	// io16 feeds both the host indication and the status word
	sock1_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_io16 (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_IO16_IN_N),
		.Q       (io16_s)
	); // R17

	// ready level, also an interrupt source
	sock1_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_ready (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_READY_IRQ),
		.Q       (ready_s)
	); // R17

	// battery voltage one / status change, also an interrupt source
	sock1_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_bvd1 (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_BATT1_STATUS_CHANGE),
		.Q       (bvd1_s)
	); // R17

	// battery voltage two / speaker; status only
	sock1_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync_bvd2 (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_BATT2_SPEAKER),
		.Q       (bvd2_s)
	); // R17

	// voltage sense pair; each bit is filtered on its own
	sock1_sync #(
		.WIDTH (2),
		.INIT  (1'b1)
	) u_sync_vs (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_VOLTAGE_SENSE_N),
		.Q       (vs_s)
	); // R17

	// card detects; strobes open only on the filtered pair
	sock1_sync #(
		.WIDTH (2),
		.INIT  (1'b1)
	) u_sync_cd (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D       (SOCK1_CARD_DETECT_N),
		.Q       (cd_s)
	); // R17

	// detect valid is active low: zero only when both detects low
	assign sock1_detect_valid_n = |cd_s; // R14

	// control register write; float bit lives here
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			card_control_reg_ff <= CTRL_RESET;
		end else if (REG_WR && REG_ADDR == CTRL_ADDR) begin
			card_control_reg_ff <= REG_WDATA[7:0]; // R15
		end
	end

	// sleep state register write
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			card_sleep_state_reg_ff <= SLEEP_RESET;
		end else if (REG_WR && REG_ADDR == SLEEP_ADDR) begin
			card_sleep_state_reg_ff <= REG_WDATA[1:0];
		end
	end

	// sleep entry and io read select polarity
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_ff <= MODE_RESET;
		end else if (REG_WR && REG_ADDR == MODE_ADDR) begin
			mode_ff <= REG_WDATA[1:0];
		end
	end

	// interrupt mask
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_mask_ff <= IRQ_MASK_RESET;
		end else if (REG_WR && REG_ADDR == IRQ_MK_ADDR) begin
			irq_mask_ff <= REG_WDATA[2:0];
		end
	end

	// reading the interrupt status clears it
	assign irq_clr = REG_RD && REG_ADDR == IRQ_ST_ADDR;

	sock1_edge u_ev_ready (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.LEVEL   (ready_s),
		.CLR     (irq_clr),
		.FLAG    (irq_flag[IRQ_READY_BIT])
	); // R10

	sock1_edge u_ev_bvd1 (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.LEVEL   (bvd1_s),
		.CLR     (irq_clr),
		.FLAG    (irq_flag[IRQ_BVD1_BIT])
	); // R11

	sock1_edge u_ev_cdv (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.LEVEL   (sock1_detect_valid_n),
		.CLR     (irq_clr),
		.FLAG    (irq_flag[IRQ_CDV_BIT])
	); // R14

	// level interrupt while any unmasked flag is set
	assign IRQ = |(irq_flag & irq_mask_ff);

	// status word of synchronised card levels
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_READY_BIT] = ready_s; // R10
		status_word[ST_CDV_BIT]   = sock1_detect_valid_n; // R14
		status_word[ST_VS1_BIT]   = vs_s[0]; // R13
		status_word[ST_VS2_BIT]   = vs_s[1]; // R13
		status_word[ST_IO16_BIT]  = io16_s; // R9
		status_word[ST_BVD1_BIT]  = bvd1_s; // R11
		status_word[ST_BVD2_BIT]  = bvd2_s; // R12
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (REG_ADDR)
			CTRL_ADDR:   nxt_rdata = {8'h00, card_control_reg_ff};
			SLEEP_ADDR:  nxt_rdata = {14'h0000, card_sleep_state_reg_ff};
			STATUS_ADDR: nxt_rdata = status_word;
			IRQ_ST_ADDR: nxt_rdata = {13'h0000, irq_flag};
			IRQ_MK_ADDR: nxt_rdata = {13'h0000, irq_mask_ff};
			MODE_ADDR:   nxt_rdata = {14'h0000, mode_ff};
			default:     nxt_rdata = 16'h0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			REG_RDATA <= nxt_rdata;
		end else begin
			REG_RDATA <= 16'h0000;
		end
	end

	// host wait is only passed when enabled, else it idles high
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HOST_WAIT_N <= 1'b1;
		end else begin
			HOST_WAIT_N <= wait_s |
				~card_control_reg_ff[CTRL_WAITEN_BIT]; // R8
		end
	end

	// host io16 indication follows the filtered card level
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HOST_IO16_N <= 1'b1;
		end else begin
			HOST_IO16_N <= io16_s; // R9
		end
	end

	assign float_en    = card_control_reg_ff[CTRL_FLOAT_BIT];
	assign sleep_mode  = mode_ff[MODE_SLEEP_BIT];
	assign sleep_drive = card_sleep_state_reg_ff[SLEEP_S1_BIT]; // R16
	// strobe gating uses the filtered detects, never the raw pins
	assign sel_ok      = ~sock1_detect_valid_n & ~SOCKET_SELECT;
	// io read polarity selectable since its qualifier may be misprinted
	assign iord_sel_ok = ~sock1_detect_valid_n &
		(SOCKET_SELECT == mode_ff[MODE_IORD_POL_BIT]);

	// strobe values: pass when qualified, high otherwise or in sleep
	always_comb begin
		if (sleep_mode) begin
			ce_n   = 2'h3; // R2
			oe_n   = 1'b1;
			we_n   = 1'b1;
			iord_n = 1'b1;
			iowr_n = 1'b1;
		end else begin
			ce_n   = sel_ok ? HOST_CARD_ENABLE_N : 2'h3; // R1
			oe_n   = sel_ok ? HOST_OUTPUT_ENABLE_N : 1'b1; // R4
			we_n   = sel_ok ? HOST_WRITE_ENABLE_N : 1'b1; // R5
			iord_n = iord_sel_ok ? HOST_IO_READ_N : 1'b1; // R6
			iowr_n = sel_ok ? HOST_IO_WRITE_N : 1'b1; // R7
		end
	end

	// float clear releases all; sleep floats unless sleep bit is one
	assign strobe_oe = float_en & (~sleep_mode | sleep_drive); // R3 R2

	// registered strobes keep the pins glitch free at one cycle of latency
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SOCK1_CARD_ENABLE_N    <= 2'h3;
			SOCK1_CARD_ENABLE_OE   <= 2'h0;
			SOCK1_OUTPUT_ENABLE_N  <= 1'b1;
			SOCK1_OUTPUT_ENABLE_OE <= 1'b0;
			SOCK1_WRITE_ENABLE_N   <= 1'b1;
			SOCK1_WRITE_ENABLE_OE  <= 1'b0;
			SOCK1_IO_READ_N        <= 1'b1;
			SOCK1_IO_READ_OE       <= 1'b0;
			SOCK1_IO_WRITE_N       <= 1'b1;
			SOCK1_IO_WRITE_OE      <= 1'b0;
		end else begin
			SOCK1_CARD_ENABLE_N    <= ce_n;
			SOCK1_CARD_ENABLE_OE   <= {2{strobe_oe}}; // R3
			SOCK1_OUTPUT_ENABLE_N  <= oe_n;
			SOCK1_OUTPUT_ENABLE_OE <= strobe_oe;
			SOCK1_WRITE_ENABLE_N   <= we_n;
			SOCK1_WRITE_ENABLE_OE  <= strobe_oe;
			SOCK1_IO_READ_N        <= iord_n;
			SOCK1_IO_READ_OE       <= strobe_oe;
			SOCK1_IO_WRITE_N       <= iowr_n;
			SOCK1_IO_WRITE_OE      <= strobe_oe;
		end
	end
endmodule

//--- tb/sock1_gate_asserts.sv
`timescale 1ns/100ps
// socket 1 pin checks against a mirror of the steering registers
module sock1_gate_asserts
	import sock1_pkg::*;
(
	input wire logic	CLK,
	input wire logic	SYS_RST,
	input wire logic [3:0]	REG_ADDR,
	input wire logic [15:0]	REG_WDATA,
	input wire logic	REG_WR,
	input wire logic	IRQ,
	input wire logic	SOCKET_SELECT,
	input wire logic	HOST_OUTPUT_ENABLE_N,
	input wire logic [1:0]	SOCK1_CARD_DETECT_N,
	input wire logic [1:0]	SOCK1_CARD_ENABLE_N,
	input wire logic [1:0]	SOCK1_CARD_ENABLE_OE,
	input wire logic	SOCK1_OUTPUT_ENABLE_N,
	input wire logic	SOCK1_OUTPUT_ENABLE_OE,
	input wire logic	SOCK1_WRITE_ENABLE_N,
	input wire logic	SOCK1_WRITE_ENABLE_OE,
	input wire logic	SOCK1_IO_READ_N,
	input wire logic	SOCK1_IO_READ_OE,
	input wire logic	SOCK1_IO_WRITE_N,
	input wire logic	SOCK1_IO_WRITE_OE
);
	import sock1_pkg::*;
	logic		flt_ff, slp_ff, sst_ff, pol_ff, awake;
	logic [2:0]	msk_ff, det_ff;
	logic [5:0]	oe, sk;
	// pins ordered ce[1:0], oe, we, io read, io write
	assign oe = {SOCK1_CARD_ENABLE_OE, SOCK1_OUTPUT_ENABLE_OE,
		SOCK1_WRITE_ENABLE_OE, SOCK1_IO_READ_OE, SOCK1_IO_WRITE_OE};
	assign sk = {SOCK1_CARD_ENABLE_N, SOCK1_OUTPUT_ENABLE_N,
		SOCK1_WRITE_ENABLE_N, SOCK1_IO_READ_N, SOCK1_IO_WRITE_N};
	assign awake = flt_ff && !slp_ff;
	// mirror of float, sleep, io read polarity and mask settings
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{flt_ff, slp_ff, sst_ff, pol_ff} <= 4'h0;
			msk_ff <= 3'h0;
		end else if (REG_WR) begin
			case (REG_ADDR)
			CTRL_ADDR: flt_ff <= REG_WDATA[CTRL_FLOAT_BIT];
			SLEEP_ADDR: sst_ff <= REG_WDATA[SLEEP_S1_BIT];
			IRQ_MK_ADDR: msk_ff <= REG_WDATA[2:0];
			MODE_ADDR: {pol_ff, slp_ff} <= REG_WDATA[1:0];
			default: ;
			endcase
		end
	end
	// seven edges of low detects: the synchroniser has surely caught up
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			det_ff <= 3'h0;
		else if (SOCK1_CARD_DETECT_N != 2'h0)
			det_ff <= 3'h0;
		else if (det_ff != 3'h7)
			det_ff <= det_ff + 3'h1;
	end
	default clocking dck @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	property p_float_off; !flt_ff |=> oe == 6'h0; endproperty
	a_float_off: assert property (p_float_off)
		else $error("strobe driven with float clear");
	property p_sleep_float; flt_ff && slp_ff && !sst_ff |=> oe == 6'h0;
	endproperty
	a_sleep_float: assert property (p_sleep_float)
		else $error("strobe driven in floating sleep");
	property p_sleep_high; flt_ff && slp_ff && sst_ff |=> (oe & sk) == 6'h3f;
	endproperty
	a_sleep_high: assert property (p_sleep_high)
		else $error("strobe not parked high in sleep");
	property p_awake_drive; awake |=> oe == 6'h3f; endproperty
	a_awake_drive: assert property (p_awake_drive)
		else $error("strobe floated while enabled");
	property p_deselect; awake && SOCKET_SELECT |=> &{sk[5:2], sk[0]};
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("strobe passed while deselected");
	property p_iord_sel; awake && SOCKET_SELECT != pol_ff |=> SOCK1_IO_READ_N;
	endproperty
	a_iord_sel: assert property (p_iord_sel)
		else $error("io read passed on wrong select");
	property p_pass; awake && !SOCKET_SELECT && det_ff == 3'h7
		|=> SOCK1_OUTPUT_ENABLE_N == $past(HOST_OUTPUT_ENABLE_N); endproperty
	a_pass: assert property (p_pass)
		else $error("output enable not forwarded");
	property p_irq_mask; msk_ff == 3'h0 |-> !IRQ; endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt with all sources masked");
	c_pass: cover property (awake && !SOCKET_SELECT && det_ff == 3'h7);
	c_sleep: cover property (flt_ff && slp_ff && sst_ff);
	c_irq: cover property ($rose(IRQ));
endmodule

//--- tb/sock1_card_model.sv
`timescale 1ns/100ps
// card in socket 1; board pull-ups hold the pins high when it is out
module sock1_card_model (
	input wire logic	present,
	input wire logic	slow,
	input wire logic	rdy,
	input wire logic	bvd1,
	input wire logic	oe_n,
	output logic [1:0]	cd_n,
	output logic [1:0]	vs_n,
	output logic		wait_n,
	output logic		ready,
	output logic		batt1,
	output logic		batt2,
	output logic		io16_n
);
	// a slow card stretches every read while its output enable is low
	assign wait_n = !(present && slow && !oe_n);
	// a 3 V card grounds the first sense pin and asks for 16-bit io
	assign cd_n = present ? 2'h0 : 2'h3;
	assign vs_n = present ? 2'h2 : 2'h3;
	assign ready = present ? rdy : 1'b1;
	assign batt1 = present ? bvd1 : 1'b1;
	assign batt2 = !present;
	assign io16_n = !present;
endmodule

//--- tb/card_socket1_pin_gating_bench.sv
`timescale 1ns/100ps
// bench: register port and host strobes in front, card model behind
module card_socket1_pin_gating_bench;
	import sock1_pkg::*;
	logic		CLK, SYS_RST, REG_WR, REG_RD, IRQ, SOCKET_SELECT;
	logic [3:0]	REG_ADDR;
	logic [15:0]	REG_WDATA, REG_RDATA;
	logic [1:0]	HOST_CARD_ENABLE_N, SOCK1_CARD_ENABLE_N;
	logic [1:0]	SOCK1_CARD_ENABLE_OE, SOCK1_VOLTAGE_SENSE_N;
	logic [1:0]	SOCK1_CARD_DETECT_N;
	logic		HOST_OUTPUT_ENABLE_N, HOST_WRITE_ENABLE_N, HOST_IO_READ_N;
	logic		HOST_IO_WRITE_N, HOST_WAIT_N, HOST_IO16_N;
	logic		SOCK1_OUTPUT_ENABLE_N, SOCK1_OUTPUT_ENABLE_OE;
	logic		SOCK1_WRITE_ENABLE_N, SOCK1_WRITE_ENABLE_OE;
	logic		SOCK1_IO_READ_N, SOCK1_IO_READ_OE;
	logic		SOCK1_IO_WRITE_N, SOCK1_IO_WRITE_OE;
	logic		SOCK1_WAIT_IN_N, SOCK1_IO16_IN_N, SOCK1_READY_IRQ;
	logic		SOCK1_BATT1_STATUS_CHANGE, SOCK1_BATT2_SPEAKER;
	logic [5:0]	hst, sk, oe;
	logic		present, slow, rdy, bvd1;
	int		fail_count, checked;
	// strobe groups ordered ce[1:0], oe, we, io read, io write
	assign {HOST_CARD_ENABLE_N, HOST_OUTPUT_ENABLE_N, HOST_WRITE_ENABLE_N,
		HOST_IO_READ_N, HOST_IO_WRITE_N} = hst;
	assign sk = {SOCK1_CARD_ENABLE_N, SOCK1_OUTPUT_ENABLE_N,
		SOCK1_WRITE_ENABLE_N, SOCK1_IO_READ_N, SOCK1_IO_WRITE_N};
	assign oe = {SOCK1_CARD_ENABLE_OE, SOCK1_OUTPUT_ENABLE_OE,
		SOCK1_WRITE_ENABLE_OE, SOCK1_IO_READ_OE, SOCK1_IO_WRITE_OE};
	sock1_gate i_sock1_gate (.*);
	// the card sees a pulled-up output enable while the pin floats
	sock1_card_model i_sock1_card_model (
		.present(present), .slow(slow), .rdy(rdy), .bvd1(bvd1),
		.oe_n(SOCK1_OUTPUT_ENABLE_OE ? SOCK1_OUTPUT_ENABLE_N : 1'b1),
		.cd_n(SOCK1_CARD_DETECT_N), .vs_n(SOCK1_VOLTAGE_SENSE_N),
		.wait_n(SOCK1_WAIT_IN_N), .ready(SOCK1_READY_IRQ),
		.batt1(SOCK1_BATT1_STATUS_CHANGE), .batt2(SOCK1_BATT2_SPEAKER),
		.io16_n(SOCK1_IO16_IN_N));
	// 100 ns clock
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		@(negedge CLK);
		chk(REG_RDATA & m, e);
	endtask
	task automatic drive(input logic s, input logic [5:0] h);
		@(posedge CLK);
		SOCKET_SELECT <= s;
		hst <= h;
		settle(1);
	endtask
	initial begin
		{SYS_RST, present, rdy, bvd1} = 4'hf;
		{REG_WR, REG_RD, SOCKET_SELECT, slow} = 4'h0;
		REG_ADDR = 4'h0;
		REG_WDATA = 16'h0;
		hst = 6'h3f;
		fail_count = 0;
		checked = 0;
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		settle(6);
		// floated pins, reset values, unmapped place and card status
		chk(16'(oe), 16'h0);
		rd(CTRL_ADDR, 16'h00ff, 16'h0);
		rd(4'hf, 16'hffff, 16'h0);
		rd(STATUS_ADDR, 16'h32ca, 16'h1082);
		chk(16'(HOST_IO16_N), 16'h0);
		// strobes pass only when selected; io read has its own level
		wr(CTRL_ADDR, 16'h0008);
		drive(1'b0, 6'h15);
		chk(16'({oe, sk}), 16'hfd5);
		drive(1'b1, 6'h15);
		chk(16'(sk), 16'h3f);
		wr(MODE_ADDR, 16'h0002);
		drive(1'b1, 6'h15);
		chk(16'(sk), 16'h3d);
		wr(MODE_ADDR, 16'h0000);
		drive(1'b0, 6'h2a);
		chk(16'(sk), 16'h2a);
		// pulling the card blocks every strobe and flags detect
		rd(IRQ_ST_ADDR, 16'h0007, 16'h0004);
		present <= 1'b0;
		settle(6);
		chk(16'(sk), 16'h3f);
		rd(STATUS_ADDR, 16'h0008, 16'h0008);
		rd(IRQ_ST_ADDR, 16'h0007, 16'h0004);
		present <= 1'b1;
		settle(6);
		// sleep floats or parks high by the socket 1 sleep bit only
		wr(MODE_ADDR, 16'h0001);
		wr(SLEEP_ADDR, 16'h0001);
		settle(1);
		chk(16'(oe), 16'h0);
		wr(SLEEP_ADDR, 16'h0002);
		settle(1);
		chk(16'({oe, sk}), 16'hfff);
		wr(MODE_ADDR, 16'h0000);
		// ready raises the line when unmasked; the read clears it
		wr(IRQ_MK_ADDR, 16'h0001);
		rd(IRQ_ST_ADDR, 16'h0007, 16'h0004);
		chk(16'(IRQ), 16'h0);
		rdy <= 1'b0;
		for (int i = 0; i < 12 && IRQ !== 1'b1; i++)
			@(negedge CLK);
		chk(16'(IRQ), 16'h1);
		if (IRQ !== 1'b1)
			give_verdict();
		rd(IRQ_ST_ADDR, 16'h0007, 16'h0001);
		chk(16'(IRQ), 16'h0);
		bvd1 <= 1'b0;
		settle(8);
		chk(16'(IRQ), 16'h0);
		rd(IRQ_ST_ADDR, 16'h0007, 16'h0002);
		rd(STATUS_ADDR, 16'h1002, 16'h0);
		// a slow card holds the host in wait while output enable is low
		wr(CTRL_ADDR, 16'h0028);
		slow <= 1'b1;
		drive(1'b0, 6'h37);
		settle(6);
		chk(16'(HOST_WAIT_N), 16'h0);
		drive(1'b0, 6'h3f);
		settle(6);
		chk(16'(HOST_WAIT_N), 16'h1);
		give_verdict();
	end
endmodule
bind sock1_gate sock1_gate_asserts i_sock1_gate_asserts (.*);
